/* etse_regs.vh */
// Constants of the channel-two evaluation block: register offsets, fields,
// reset values and timing counts. Assumes a 40 MHz system clock.
`ifndef ETSE_REGS_VH
`define ETSE_REGS_VH
// ----------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define ETSE_OFS_CTRL 8'h00
`define ETSE_OFS_REF_FREQ 8'h04
`define ETSE_OFS_REF_DISP 8'h08
`define ETSE_OFS_SIM_FREQ 8'h0C
`define ETSE_OFS_HOLD 8'h10
`define ETSE_OFS_WAIT 8'h14
`define ETSE_OFS_STATUS 8'h18
`define ETSE_OFS_DISPLAY 8'h1C
`define ETSE_OFS_CLOCK 8'h20
`define ETSE_OFS_MINIMUM 8'h24
// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define ETSE_CTRL_SHAPE_LSB 0
`define ETSE_CTRL_DELAY_LSB 4
`define ETSE_CTRL_OPMODE_LSB 8
`define ETSE_CTRL_DELAY1_LSB 12
`define ETSE_CTRL_COMBINED_BIT 16
`define ETSE_CTRL_SIM_BIT 17
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ETSE_RST_REF 20'h003E8
`define ETSE_RST_WAIT 14'h0064
`define ETSE_RST_ZERO 32'h00000000
// ----------------------------------------------------------------------
// Limits and timing
// ----------------------------------------------------------------------
`define ETSE_DEC_MAX 20'hF423F
`define ETSE_MIN_MAX 14'h270F
`define ETSE_HRS_MAX 7'h63
`define ETSE_SIXTY 32'h0000003C
`define ETSE_CLK_HZ 40000000
`define ETSE_TICK_SEC_NS 10000000
`define ETSE_CLK_NS 25
`define ETSE_TICK_CYC (`ETSE_TICK_SEC_NS / `ETSE_CLK_NS)
`define ETSE_DELAY_OFF 4'h0
`define ETSE_DELAY_AUTO 4'h9
`define ETSE_DELAY_EXT 4'hA
`endif

/* etse_tick.v */
// Hundredth-of-a-second tick generator.
// Assumes a free running 40 MHz clock.
`timescale 1ns/1ps
`include "etse_regs.vh"
module etse_tick #(
   parameter TICK_CYC = `ETSE_TICK_CYC
) (
   input wire i_clk,
   input wire i_rst,
   output reg o_tick
);
   reg [31:0] count;
   // Count up one period, pulse on wrap
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         count <= 32'h00000000;
         o_tick <= 1'b0;
      end else if (count == TICK_CYC - 1) begin
         count <= 32'h00000000;
         o_tick <= 1'b1;
      end else begin
         count <= count + 32'h00000001;
         o_tick <= 1'b0;
      end
   end
endmodule // etse_tick

/* etse_divider.v */
// Sequential unsigned divider, one quotient bit per clock.
// Assumes the start pulse is only given while idle.
`timescale 1ns/1ps
module etse_divider (
   input wire i_clk,
   input wire i_rst,
   input wire i_start,
   input wire [47:0] i_num,
   input wire [23:0] i_den,
   output reg o_done,
   output reg [47:0] o_quot
);
   reg [47:0] num;
   reg [24:0] rem;
   reg [5:0] bit_cnt;
   reg busy;
   wire [24:0] trial;
   assign trial = {rem[23:0], num[47]} - {1'b0, i_den};
   // Restoring division; slow but tiny, display needs no speed
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         num <= 48'h000000000000;
         rem <= 25'h0000000;
         bit_cnt <= 6'h00;
         busy <= 1'b0;
         o_done <= 1'b0;
         o_quot <= 48'h000000000000;
      end else begin
         o_done <= 1'b0;
         if (i_start && !busy) begin
            num <= i_num;
            rem <= 25'h0000000;
            bit_cnt <= 6'h30;
            busy <= 1'b1;
         end else if (busy) begin
            if (trial[24]) begin
               rem <= {rem[23:0], num[47]};
            end else begin
               rem <= trial;
            end
            num <= {num[46:0], ~trial[24]};
            bit_cnt <= bit_cnt - 6'h01;
            if (bit_cnt == 6'h01) begin
               busy <= 1'b0;
               o_done <= 1'b1;
               o_quot <= {num[46:0], ~trial[24]};
            end
         end
      end
   end
endmodule // etse_divider

/* etse_eval.v */
// Channel-two speed evaluation: display scaling, simulated frequency,
// start-up suppression and standstill. Assumes a measured frequency in
// hundredths of a hertz with a one-cycle strobe for each new pulse.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "etse_regs.vh"
module etse_eval #(
   parameter TICK_CYC = `ETSE_TICK_CYC
) (
   input wire i_clk,
   input wire i_rst,
   input wire [7:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [31:0] o_rdata,
   input wire [19:0] i_meas_freq,
   input wire i_pulse,
   input wire i_remote_delay,
   output reg o_suppress_output_two,
   output reg o_suppress_output_three,
   output reg o_suppress_output_four,
   output reg o_standstill,
   output reg [19:0] o_display,
   output reg [20:0] o_eff_freq
);
   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   reg [1:0] shape;
   reg [3:0] delay_sel;
   reg [3:0] delay_one;
   reg [3:0] op_mode;
   reg combined;
   reg sim_on;
   reg [19:0] ref_freq;
   reg [19:0] ref_disp;
   reg [20:0] sim_freq;
   reg [13:0] hold_time;
   reg [13:0] wait_time;
   reg [19:0] minimum;
   reg [19:0] meas_held;
   reg [13:0] wait_cnt;
   reg [13:0] hold_cnt;
   reg [14:0] delay_cnt;
   reg delay_run;
   reg auto_wait;
   reg zero_seen;
   reg [13:0] clk_min;
   reg [5:0] clk_sec;
   reg [6:0] clk_hrs;
   reg [1:0] phase;
   reg div_start;
   reg [47:0] div_num;
   reg [23:0] div_den;
   reg [20:0] next_eff;
   reg next_active;
   wire tick;
   wire div_done;
   wire [47:0] quot;
   wire [19:0] mag;
   wire [3:0] eff_delay;
   wire delay_restart;
   wire sup;
   // Clock-format pieces, cut to field width on purpose below
   wire [19:0] q_min = quot[19:0] / 20'd60;
   wire [19:0] q_sec = quot[19:0] % 20'd60;
   wire [18:0] q_hrs = quot[18:0] / 19'd3600;
   wire [18:0] q_hmin = quot[18:0] / 19'd60 % 19'd60;

   // Clamp a scaling value to the legal 1..999999 window
   function [19:0] etse_clamp;
      input [31:0] v;
      begin
         if (v[19:0] == 20'h00000) begin
            etse_clamp = 20'h00001;
         end else if (v > {12'h000, `ETSE_DEC_MAX}) begin
            etse_clamp = `ETSE_DEC_MAX;
         end else begin
            etse_clamp = v[19:0];
         end
      end
   endfunction

   // Saturate a quotient to a decimal display limit
   function [19:0] etse_sat;
      input [47:0] q;
      begin
         if (q > {28'h0000000, `ETSE_DEC_MAX}) begin
            etse_sat = `ETSE_DEC_MAX;
         end else begin
            etse_sat = q[19:0];
         end
      end
   endfunction

   // Software writes; scaling pair clamped on entry
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         shape <= 2'h0;
         delay_sel <= 4'h0;
         delay_one <= 4'h0;
         op_mode <= 4'h0;
         combined <= 1'b0;
         sim_on <= 1'b0;
         ref_freq <= `ETSE_RST_REF;
         ref_disp <= `ETSE_RST_REF;
         sim_freq <= 21'h000000;
         hold_time <= 14'h0000;
         wait_time <= `ETSE_RST_WAIT;
         minimum <= 20'h00000;
      end else if (i_wr) begin
         case (i_addr)
            `ETSE_OFS_CTRL: begin
               shape <= i_wdata[`ETSE_CTRL_SHAPE_LSB +: 2];
               delay_sel <= (i_wdata[`ETSE_CTRL_DELAY_LSB +: 4] > `ETSE_DELAY_EXT) ?
                  `ETSE_DELAY_EXT : i_wdata[`ETSE_CTRL_DELAY_LSB +: 4];
               op_mode <= i_wdata[`ETSE_CTRL_OPMODE_LSB +: 4];
               delay_one <= i_wdata[`ETSE_CTRL_DELAY1_LSB +: 4];
               combined <= i_wdata[`ETSE_CTRL_COMBINED_BIT];
               sim_on <= i_wdata[`ETSE_CTRL_SIM_BIT];
            end
            `ETSE_OFS_REF_FREQ: ref_freq <= etse_clamp(i_wdata);
            `ETSE_OFS_REF_DISP: ref_disp <= etse_clamp(i_wdata);
            `ETSE_OFS_SIM_FREQ: sim_freq <= i_wdata[20:0];
            `ETSE_OFS_HOLD: hold_time <= (i_wdata[13:0] > 14'h270F) ? 14'h270F : i_wdata[13:0];
            `ETSE_OFS_WAIT: wait_time <= (i_wdata[13:0] == 14'h0000) ? 14'h0001 :
               ((i_wdata[13:0] > 14'h270F) ? 14'h270F : i_wdata[13:0]);
            `ETSE_OFS_MINIMUM: minimum <= i_wdata[19:0];
            default: ;
         endcase
      end
   end

   // Read data one cycle after the strobe, zero elsewhere
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= `ETSE_RST_ZERO;
      end else if (i_rd) begin
         case (i_addr)
            `ETSE_OFS_CTRL: o_rdata <= {14'h0000, sim_on, combined, delay_one,
               op_mode, delay_sel, 2'h0, shape};
            `ETSE_OFS_REF_FREQ: o_rdata <= {12'h000, ref_freq};
            `ETSE_OFS_REF_DISP: o_rdata <= {12'h000, ref_disp};
            `ETSE_OFS_SIM_FREQ: o_rdata <= {{11{sim_freq[20]}}, sim_freq};
            `ETSE_OFS_HOLD: o_rdata <= {18'h00000, hold_time};
            `ETSE_OFS_WAIT: o_rdata <= {18'h00000, wait_time};
            `ETSE_OFS_STATUS: o_rdata <= {27'h0000000, delay_run, o_suppress_output_four,
               o_suppress_output_three, o_suppress_output_two, o_standstill};
            `ETSE_OFS_DISPLAY: o_rdata <= {12'h000, o_display};
            `ETSE_OFS_CLOCK: o_rdata <= {5'h00, clk_hrs, clk_min, clk_sec};
            `ETSE_OFS_MINIMUM: o_rdata <= {12'h000, minimum};
            default: o_rdata <= `ETSE_RST_ZERO;
         endcase
      end else begin
         o_rdata <= `ETSE_RST_ZERO;
      end
   end

   // ----------------------------------------------------------------------
   // Frequency source
   // ----------------------------------------------------------------------
   etse_tick #(.TICK_CYC(TICK_CYC)) u_tick (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .o_tick(tick)
   );

   // Wait-time watchdog in hundredths; shortest sampling takes every pulse
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meas_held <= 20'h00000;
         wait_cnt <= 14'h0000;
      end else if (i_pulse) begin
         meas_held <= i_meas_freq;
         wait_cnt <= 14'h0000;
      end else if (tick) begin
         if (wait_cnt + 14'h0001 >= wait_time) begin
            meas_held <= 20'h00000;
         end else begin
            wait_cnt <= wait_cnt + 14'h0001;
         end
      end
   end

   // Simulated value stands in for the real one everywhere downstream
   always @* begin
      next_eff = sim_on ? sim_freq : {1'b0, meas_held};
   end

   assign mag = next_eff[20] ? 20'h00000 : next_eff[19:0];

   // ----------------------------------------------------------------------
   // Display scaling
   // ----------------------------------------------------------------------
   etse_divider u_div (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_start(div_start),
      .i_num(div_num),
      .i_den(div_den),
      .o_done(div_done),
      .o_quot(quot)
   );

   // Launch one division per update; result in whole display units.
   // Negative simulated rates count as a zero rate, a limitation of the unsigned path.
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         phase <= 2'h0;
         div_start <= 1'b0;
         div_num <= 48'h000000000000;
         div_den <= 24'h000000;
         o_display <= 20'h00000;
         o_eff_freq <= 21'h000000;
         clk_min <= 14'h0000;
         clk_sec <= 6'h00;
         clk_hrs <= 7'h00;
      end else begin
         div_start <= 1'b0;
         o_eff_freq <= next_eff;
         case (phase)
            2'h0: begin
               if (shape == 2'h0) begin
                  // Divide the numerator by 100 first so hundredths come out as whole display units
                  div_num <= mag * ref_disp / 48'd100;
                  div_den <= {4'h0, ref_freq};
                  div_start <= 1'b1;
                  phase <= 2'h1;
               end else if (mag == 20'h00000) begin
                  o_display <= `ETSE_DEC_MAX; // Infinite time saturates
                  clk_min <= (shape == 2'h3) ? 14'h003B : `ETSE_MIN_MAX;
                  clk_sec <= 6'h3B;
                  clk_hrs <= `ETSE_HRS_MAX;
               end else begin
                  div_num <= ref_disp * ref_freq * 48'h000000000064;
                  div_den <= {4'h0, mag};
                  div_start <= 1'b1;
                  phase <= 2'h1;
               end
            end
            2'h1: phase <= 2'h2;
            2'h2: begin
               if (div_done) begin
                  o_display <= etse_sat(quot);
                  // Minutes and seconds format
                  if (quot >= 48'd600000) begin
                     clk_min <= `ETSE_MIN_MAX;
                     clk_sec <= 6'h3B;
                  end else begin
                     clk_min <= q_min[13:0];
                     clk_sec <= q_sec[5:0];
                  end
                  // Hours, minutes and seconds format
                  if (quot >= 48'd360000) begin
                     clk_hrs <= `ETSE_HRS_MAX;
                  end else begin
                     clk_hrs <= q_hrs[6:0];
                  end
                  if (shape == 2'h3) begin
                     clk_min <= (quot >= 48'd360000) ? 14'h003B : q_hmin[13:0];
                  end
                  phase <= 2'h0;
               end
            end
            default: phase <= 2'h0;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Standstill and start-up delay
   // ----------------------------------------------------------------------
   // Hold time runs after zero, restarts on any nonzero rate
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         hold_cnt <= 14'h0000;
         zero_seen <= 1'b0;
         o_standstill <= 1'b0;
      end else if (mag != 20'h00000) begin
         hold_cnt <= 14'h0000;
         zero_seen <= 1'b0;
         o_standstill <= 1'b0;
      end else begin
         zero_seen <= 1'b1;
         if (zero_seen && !o_standstill && hold_cnt >= hold_time) begin
            o_standstill <= 1'b1;
         end else if (tick && !o_standstill) begin
            hold_cnt <= hold_cnt + 14'h0001;
         end
      end
   end

   // Longer of the two settings in combined modes
   assign eff_delay = (combined && delay_one > delay_sel) ? delay_one : delay_sel;
   assign delay_restart = o_standstill && !zero_seen;
   reg stand_q;
   reg armed;
   // Arm at power-up and on each new standstill
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         stand_q <= 1'b0;
         armed <= 1'b1;
         delay_cnt <= 15'h0000;
         delay_run <= 1'b0;
         auto_wait <= 1'b0;
      end else begin
         stand_q <= o_standstill;
         armed <= 1'b0;
         if (armed || (o_standstill && !stand_q)) begin
            delay_run <= (eff_delay != `ETSE_DELAY_OFF);
            auto_wait <= (eff_delay == `ETSE_DELAY_AUTO);
            delay_cnt <= 15'h0000;
         end else if (delay_run) begin
            if (eff_delay == `ETSE_DELAY_AUTO) begin
               if (o_display > minimum) begin
                  delay_run <= 1'b0;
               end
            end else if (eff_delay != `ETSE_DELAY_EXT) begin
               if (tick) begin
                  delay_cnt <= delay_cnt + 15'h0001;
               end
               // 2^(n-1) seconds in hundredths
               if (eff_delay == `ETSE_DELAY_OFF ||
                   delay_cnt >= (15'd100 << (eff_delay - 4'h1))) begin
                  delay_run <= 1'b0;
               end
            end
         end
      end
   end

   assign sup = (delay_run && eff_delay != `ETSE_DELAY_EXT) ||
                (eff_delay == `ETSE_DELAY_EXT && i_remote_delay);

   // Route suppression by operational mode
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_suppress_output_two <= 1'b0;
         o_suppress_output_three <= 1'b0;
         o_suppress_output_four <= 1'b0;
      end else begin
         o_suppress_output_two <= 1'b0;
         o_suppress_output_three <= 1'b0;
         o_suppress_output_four <= 1'b0;
         if (op_mode == 4'h1) begin
            o_suppress_output_three <= sup;
            o_suppress_output_four <= sup;
         end else if (op_mode >= 4'h2 && op_mode <= 4'h8) begin
            o_suppress_output_two <= sup;
         end
      end
   end
endmodule // etse_eval

/* etse_pulse_model.sv */
// Encoder-side model: one-cycle strobes carrying a fixed frequency.
// Assumes the bench starts and stops it through i_run.
`timescale 1ns/1ps
module etse_pulse_model #(
   parameter GAP = 7,
   parameter FREQ = 20'h01388
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_run,
   output reg o_pulse,
   output reg [19:0] o_freq
);
// ------------------------------------------------------------
// Pulse source
// ------------------------------------------------------------
integer cnt;
// Value churns between strobes so nothing relies on a stale level
always @(posedge i_clk or posedge i_rst) begin
   if (i_rst) begin
      cnt <= 0;
      o_pulse <= 1'b0;
      o_freq <= 20'h00000;
   end else begin
      o_pulse <= i_run && cnt == GAP;
      o_freq <= (i_run && cnt == GAP) ? FREQ : ~o_freq;
      cnt <= (!i_run || cnt == GAP) ? 0 : cnt + 1;
   end
end
endmodule // etse_pulse_model

/* etse_eval_asserts.sv */
// Port checker for the channel-two evaluation block.
// Assumes writes take effect one cycle after the strobe.
`timescale 1ns/1ps
`include "etse_regs.vh"
module etse_eval_asserts #(
   parameter TICK_CYC = 10
) (
   input wire i_clk,
   input wire i_rst,
   input wire [7:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [31:0] o_rdata,
   input wire [19:0] i_meas_freq,
   input wire i_pulse,
   input wire i_remote_delay,
   input wire o_suppress_output_two,
   input wire o_suppress_output_three,
   input wire o_suppress_output_four,
   input wire o_standstill,
   input wire [19:0] o_display,
   input wire [20:0] o_eff_freq
);
// ------------------------------------------------------------
// Shadow settings and counters
// ------------------------------------------------------------
reg [31:0] ctrl;
reg [20:0] sim;
reg [13:0] hold;
reg [13:0] wait_t;
integer age;
integer quiet;
wire [3:0] dly = ctrl[7:4];
wire [3:0] mode = ctrl[11:8];
wire ch1_off = ctrl[15:12] == 4'h0 && !ctrl[16];
wire sim_live = ctrl[17] && !sim[20] && sim != 21'h000000;
wire settled = age >= 4;
wire cfg_rem = settled && dly == 4'hA && mode >= 4'h2 && mode <= 4'h8 && ch1_off;
wire sup_any = o_suppress_output_two || o_suppress_output_three || o_suppress_output_four;
// Quiet counts cycles with no nonzero frequency; saturates to stay small
always @(posedge i_clk or posedge i_rst) begin
   if (i_rst) begin
      ctrl <= 32'h00000000;
      sim <= 21'h000000;
      hold <= 14'h0000;
      wait_t <= 14'h0064;
      age <= 0;
      quiet <= 0;
   end else begin
      age <= i_wr ? 0 : (age < 100000 ? age + 1 : age);
      quiet <= (sim_live || (i_pulse && i_meas_freq != 20'h00000 && !ctrl[17])) ? 0 :
         (quiet < 100000 ? quiet + 1 : quiet);
      if (i_wr && i_addr == `ETSE_OFS_CTRL) ctrl <= i_wdata;
      if (i_wr && i_addr == `ETSE_OFS_SIM_FREQ) sim <= i_wdata[20:0];
      if (i_wr && i_addr == `ETSE_OFS_HOLD) hold <= i_wdata[13:0];
      if (i_wr && i_addr == `ETSE_OFS_WAIT) wait_t <= i_wdata[13:0];
   end
end
// ------------------------------------------------------------
// Properties
// ------------------------------------------------------------
default clocking cb @(posedge i_clk); endclocking
default disable iff (i_rst);
sequence remote_held;
   (cfg_rem && i_remote_delay) [*3];
endsequence
sequence remote_clear;
   (cfg_rem && !i_remote_delay) [*3];
endsequence
a_mode0_quiet: assert property (settled && mode == 4'h0 && ch1_off |-> !sup_any)
   else $error("suppression in mode zero");
a_delay_off: assert property (settled && dly == 4'h0 && ch1_off |-> !sup_any)
   else $error("suppression with delay off");
a_mode1_skip: assert property (settled && mode == 4'h1 && ch1_off |-> !o_suppress_output_two)
   else $error("output two suppressed in mode one");
a_only_two: assert property (settled && mode >= 4'h2 && mode <= 4'h8 |->
   !o_suppress_output_three && !o_suppress_output_four) else $error("wrong output suppressed");
a_remote_on: assert property (remote_held |-> o_suppress_output_two)
   else $error("remote request ignored");
a_remote_clear: assert property (remote_clear |-> !o_suppress_output_two)
   else $error("suppression without remote request");
a_sim_value: assert property (settled && ctrl[17] |-> o_eff_freq == sim)
   else $error("effective frequency not the simulated one");
a_recip_sat: assert property (age >= 100 && ctrl[17] && ctrl[1:0] == 2'h1 &&
   (sim == 21'h000000 || sim[20]) |-> o_display == `ETSE_DEC_MAX) else $error("no saturation");
a_hold_lower: assert property ($rose(o_standstill) |-> quiet + TICK_CYC >= hold * TICK_CYC)
   else $error("standstill before hold time");
a_hold_upper: assert property (quiet >= (wait_t + hold + 3) * TICK_CYC &&
   age >= (wait_t + hold + 3) * TICK_CYC |-> o_standstill) else $error("standstill late");
endmodule // etse_eval_asserts

/* etse_eval_tb.sv */
// Self-checking bench for the channel-two evaluation block.
// Assumes the pulse model as encoder side and a ten-cycle tick.
`timescale 1ns/1ps
`include "etse_regs.vh"
module etse_eval_tb;
typedef struct packed {
   logic [1:0] shape;
   logic [20:0] sim;
   logic [19:0] rf;
   logic [19:0] rd;
   logic [31:0] exp;
} etse_row_t;
reg i_clk, i_rst, i_wr, i_rd, i_remote_delay, p_run;
reg [7:0] i_addr;
reg [31:0] i_wdata;
wire [31:0] o_rdata;
wire [19:0] meas, disp;
wire [20:0] eff;
wire pulse, sup2, sup3, sup4, still;
etse_row_t rows [0:9];
integer fail_count, check_count, cyc, i, n;
etse_eval #(.TICK_CYC(10)) etse_eval_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_meas_freq(meas),
   .i_pulse(pulse), .i_remote_delay(i_remote_delay), .o_suppress_output_two(sup2),
   .o_suppress_output_three(sup3), .o_suppress_output_four(sup4), .o_standstill(still),
   .o_display(disp), .o_eff_freq(eff));
etse_pulse_model etse_pulse_model_inst (.i_clk(i_clk), .i_rst(i_rst), .i_run(p_run),
   .o_pulse(pulse), .o_freq(meas));
// ------------------------------------------------------------
// Tasks
// ------------------------------------------------------------
task check(input [31:0] seen, input [31:0] want);
   begin
      check_count = check_count + 1;
      if (seen !== want) begin
         fail_count = fail_count + 1;
         $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
   end
endtask
task bus_wr(input [7:0] a, input [31:0] d);
   begin
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   end
endtask
task rd_check(input [7:0] a, input [31:0] want);
   begin
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      check(o_rdata, want);
   end
endtask
// Sample away from the rising edge so updates have landed
task settle(input integer c);
   begin
      repeat (c) @(posedge i_clk);
      @(negedge i_clk);
   end
endtask
task close_out;
   begin
      if (fail_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
endtask
// ------------------------------------------------------------
// Clock, timeout and sequence
// ------------------------------------------------------------
initial begin
   i_clk = 1'b0;
   forever #12.5 i_clk = ~i_clk;
end
// Run needs about 4000 cycles; a hang is cut off well after that
always @(posedge i_clk) begin
   cyc <= cyc + 1;
   if (cyc == 12000) begin
      fail_count = fail_count + 1;
      close_out;
   end
end
initial begin
   i_rst = 1'b1;
   i_addr = 8'h00;
   i_wdata = 32'h00000000;
   i_wr = 1'b0;
   i_rd = 1'b0;
   i_remote_delay = 1'b0;
   p_run = 1'b0;
   fail_count = 0;
   check_count = 0;
   cyc = 0;
   rows[0] = '{2'h0, 21'h0007D0, 20'h003E8, 20'h003E8, 32'h00000014};
   rows[1] = '{2'h0, 21'h003039, 20'h00032, 20'h00190, 32'h000003DB};
   rows[2] = '{2'h0, 21'h000064, 20'h00001, 20'hF423F, 32'h000F423F};
   rows[3] = '{2'h1, 21'h0007D0, 20'h003E8, 20'h003E8, 32'h0000C350};
   rows[4] = '{2'h1, 21'h000001, 20'h003E8, 20'h003E8, 32'h000F423F};
   rows[5] = '{2'h1, 21'h1FFFFB, 20'h003E8, 20'h003E8, 32'h000F423F};
   rows[6] = '{2'h2, 21'h0007D0, 20'h003E8, 20'h003E8, 32'h00D0D054};
   rows[7] = '{2'h2, 21'h000000, 20'h003E8, 20'h003E8, 32'h0639C3FB};
   rows[8] = '{2'h3, 21'h0007D0, 20'h003E8, 20'h003E8, 32'h00D00D54};
   rows[9] = '{2'h3, 21'h000000, 20'h003E8, 20'h003E8, 32'h06300EFB};
   repeat (20) @(posedge i_clk);
   i_rst <= 1'b0;
   // Display shapes driven by the simulated frequency
   for (i = 0; i < 10; i = i + 1) begin
      bus_wr(`ETSE_OFS_REF_FREQ, {12'h000, rows[i].rf});
      bus_wr(`ETSE_OFS_REF_DISP, {12'h000, rows[i].rd});
      bus_wr(`ETSE_OFS_SIM_FREQ, {11'h000, rows[i].sim});
      bus_wr(`ETSE_OFS_CTRL, {30'h00008000, rows[i].shape});
      settle(150);
      check(eff, rows[i].sim);
      if (rows[i].shape[1])
         rd_check(`ETSE_OFS_CLOCK, rows[i].exp);
      else
         check(disp, rows[i].exp);
   end
   // Remote request against each mode family
   for (i = 0; i < 4; i = i + 1) begin
      n = (i == 3) ? 8 : i;
      bus_wr(`ETSE_OFS_CTRL, n * 256 + 160);
      @(posedge i_clk) i_remote_delay <= 1'b1;
      settle(10);
      check({sup4, sup3, sup2}, (n == 0) ? 3'h0 : ((n == 1) ? 3'h6 : 3'h1));
      @(posedge i_clk) i_remote_delay <= 1'b0;
      settle(10);
      check({sup4, sup3, sup2}, 3'h0);
      bus_wr(`ETSE_OFS_CTRL, n * 256);
      @(posedge i_clk) i_remote_delay <= 1'b1;
      settle(10);
      check({sup4, sup3, sup2}, 3'h0);
      @(posedge i_clk) i_remote_delay <= 1'b0;
   end
   // Standstill after wait and hold, then a one-second timed delay
   bus_wr(`ETSE_OFS_WAIT, 32'h00000002);
   bus_wr(`ETSE_OFS_HOLD, 32'h00000005);
   bus_wr(`ETSE_OFS_CTRL, 32'h00000210);
   @(posedge i_clk) p_run <= 1'b1;
   settle(200);
   check(still, 1'b0);
   @(posedge i_clk) p_run <= 1'b0;
   settle(25);
   @(posedge i_clk) p_run <= 1'b1;
   settle(30);
   check(still, 1'b0);
   @(posedge i_clk) p_run <= 1'b0;
   n = 0;
   while (still !== 1'b1 && n < 400) begin
      @(negedge i_clk);
      n = n + 1;
   end
   check(n >= 40 && n <= 100, 1'b1);
   settle(3);
   check(sup2, 1'b1);
   n = 4;
   while (sup2 === 1'b1 && n < 1500) begin
      @(negedge i_clk);
      n = n + 1;
   end
   check(n >= 980 && n <= 1020, 1'b1);
   // Delay held until the display first exceeds the minimum
   bus_wr(`ETSE_OFS_MINIMUM, 32'h00000003);
   bus_wr(`ETSE_OFS_SIM_FREQ, 32'h000001F4);
   bus_wr(`ETSE_OFS_CTRL, 32'h00020290);
   settle(100);
   check(still, 1'b0);
   bus_wr(`ETSE_OFS_SIM_FREQ, 32'h00000000);
   settle(150);
   check(still, 1'b1);
   check(sup2, 1'b1);
   bus_wr(`ETSE_OFS_SIM_FREQ, 32'h00000064);
   settle(150);
   check(sup2, 1'b1);
   bus_wr(`ETSE_OFS_SIM_FREQ, 32'h000003E8);
   settle(150);
   check(sup2, 1'b0);
   // Clamping, unmapped read and a second reset
   bus_wr(`ETSE_OFS_REF_FREQ, 32'h00000000);
   rd_check(`ETSE_OFS_REF_FREQ, 32'h00000001);
   bus_wr(`ETSE_OFS_REF_FREQ, 32'h000FFFFF);
   rd_check(`ETSE_OFS_REF_FREQ, 32'h000F423F);
   rd_check(8'h40, 32'h00000000);
   @(posedge i_clk) i_rst <= 1'b1;
   repeat (3) @(posedge i_clk);
   i_rst <= 1'b0;
   rd_check(`ETSE_OFS_REF_FREQ, 32'h000003E8);
   rd_check(`ETSE_OFS_REF_DISP, 32'h000003E8);
   rd_check(`ETSE_OFS_WAIT, 32'h00000064);
   rd_check(`ETSE_OFS_HOLD, 32'h00000000);
   rd_check(`ETSE_OFS_CTRL, 32'h00000000);
   close_out;
end
endmodule // etse_eval_tb
bind etse_eval etse_eval_asserts #(.TICK_CYC(TICK_CYC)) etse_eval_asserts_inst (
   .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_meas_freq(i_meas_freq), .i_pulse(i_pulse),
   .i_remote_delay(i_remote_delay), .o_suppress_output_two(o_suppress_output_two),
   .o_suppress_output_three(o_suppress_output_three),
   .o_suppress_output_four(o_suppress_output_four), .o_standstill(o_standstill),
   .o_display(o_display), .o_eff_freq(o_eff_freq));
